// *** design/meter_reset_port_select_seq.sv ***
/*
  Reset, power-up and host port select sequencer of a polyphase metering
  device: supply hold, power modes, pin and software reset, reset-done
  flag with its interrupt pin, I2C/SPI selection and lock, processor run.
  Assumes the serial port logic on ref_clk delivers one-cycle write
  strobes with a shared data word; pins are asynchronous and synchronised.
*/
// Contract
// R1 - stay inactive, then hold 26 ms after supply
// R2 - host drives mode pin b low first
// R3 - host keeps reset pin high during power-up
// R4 - normal mode starts on I2C; three falls pick SPI
// R5 - I2C lock bit fixes I2C, toggles ignored
// R6 - any second_config_reg write locks an active SPI
// R7 - only power loss or pin reset frees lock
// R8 - locked port kept across power mode changes
// R9 - entering normal mode loads all defaults
// R10 - done flag low in transition, set at end
// R11 - writing one clears flag, releases interrupt pin
// R12 - host waits for interrupt, then clears flags
// R13 - processor idle until run gets 0x0001
// R14 - supply loss returns device to inactive
// R15 - host writes modulator fix after bad power-up
// R16 - reset pin honoured only in normal mode
// R17 - reset pulse of 10 us restores all defaults
// R18 - SPI host reselects port after pin reset
// R19 - software reset bit starts reset in normal
// R20 - software reset keeps second_config_reg, level, lock
// R21 - software reset end clears bit, sets flag
// R22 - software reset ignored in reduced modes
// R23 - writing zero leaves done flag unchanged
`default_nettype none

module meter_reset_port_select_seq #(
  parameter int unsigned HOLD_CYCLES   = meter_reset_pkg::HOLD_CYCLES_DEF,
  parameter int unsigned SETTLE_CYCLES = meter_reset_pkg::SETTLE_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // device pins
  input  wire logic        supplyOk,
  input  wire logic        powerModePinA,
  input  wire logic        powerModePinB,
  input  wire logic        resetPinN,
  input  wire logic        slaveSelectPinN,
  // register writes from the serial port
  input  wire logic        cfgWr,
  input  wire logic        secondCfgWr,
  input  wire logic        secondStatusWr,
  input  wire logic        runWr,
  input  wire logic [15:0] wrData,
  // status and control
  output logic             deviceActive,
  output logic             normalMode,
  output logic             transitionBusy,
  output logic             resetDoneFlag,
  output logic             doneIrqN,
  output logic             softwareResetBit,
  output logic             spiActive,
  output logic             i2cLocked,
  output logic             spiLocked,
  output logic             dspRun,
  output logic             loadAllDefaults,
  output logic             loadCoreDefaults
);

  localparam int CW = meter_reset_pkg::CNT_W;
  localparam logic [CW-1:0] HOLD_LIM   = CW'(HOLD_CYCLES - 1);
  localparam logic [CW-1:0] SETTLE_LIM = CW'(SETTLE_CYCLES - 1);
  localparam logic [CW-1:0] XFER_LIM   =
    CW'(meter_reset_pkg::XFER_CYCLES - 1);
  localparam logic [CW-1:0] PULSE_LIM  =
    CW'(meter_reset_pkg::RESET_PULSE_CYCLES - 1);
  localparam logic [CW-1:0] CNT_MAX    = {CW{1'b1}};
  localparam logic [CW-1:0] CNT_ZERO   = {CW{1'b0}};

  function automatic logic timerDone(input logic [CW-1:0] cnt,
                                     input logic [CW-1:0] lim);
    timerDone = (cnt >= lim);
  endfunction

  function automatic meter_reset_pkg::mode_type decodeMode(
    input logic [1:0] pins);
    if (pins == meter_reset_pkg::PINS_NORMAL) begin
      decodeMode = meter_reset_pkg::MODE_NORMAL;
    end else if (pins == meter_reset_pkg::PINS_REDUCED) begin
      decodeMode = meter_reset_pkg::MODE_REDUCED;
    end else if (pins == meter_reset_pkg::PINS_LOW) begin
      decodeMode = meter_reset_pkg::MODE_LOW;
    end else begin
      decodeMode = meter_reset_pkg::MODE_SLEEP;
    end
  endfunction

  // pin synchronisers; the first stage feeds only the second
  // reset to the idle pin levels so no false select edge follows reset
  localparam logic [4:0] PIN_IDLE = 5'h18;
  logic [4:0] pinMeta_ff;
  logic [4:0] pinSync_ff;
  logic       ssPrev_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pinMeta_ff <= PIN_IDLE;
      pinSync_ff <= PIN_IDLE;
      ssPrev_ff  <= 1'b1;
    end else begin
      pinMeta_ff <= {slaveSelectPinN, resetPinN, powerModePinB,
                     powerModePinA, supplyOk};
      pinSync_ff <= pinMeta_ff;
      ssPrev_ff  <= pinSync_ff[4];
    end
  end

  logic supplyGood;
  logic rstPinHigh;
  logic ssFall;
  logic modeIsNormal;

  assign supplyGood   = pinSync_ff[0];
  assign rstPinHigh   = pinSync_ff[3];
  assign ssFall       = ssPrev_ff && !pinSync_ff[4];
  assign modeIsNormal = (decodeMode(pinSync_ff[2:1]) ==
                         meter_reset_pkg::MODE_NORMAL);

  // sequencer
  meter_reset_pkg::state_type state_ff;
  meter_reset_pkg::state_type nxt_state;
  logic [CW-1:0]              cnt_ff;
  logic                       swRstReq;

  assign swRstReq = cfgWr && wrData[meter_reset_pkg::SOFTWARE_RESET_BIT_BIT];

  always_comb begin
    nxt_state = state_ff;
    if (!supplyGood) begin
      nxt_state = meter_reset_pkg::ST_INACTIVE; // R14
    end else begin
      case (state_ff)
        meter_reset_pkg::ST_INACTIVE: begin
          nxt_state = meter_reset_pkg::ST_HOLD;
        end
        meter_reset_pkg::ST_HOLD: begin
          if (timerDone(cnt_ff, HOLD_LIM)) begin
            nxt_state = meter_reset_pkg::ST_SETTLE; // R1
          end
        end
        meter_reset_pkg::ST_SETTLE: begin
          if (timerDone(cnt_ff, SETTLE_LIM)) begin
            nxt_state = meter_reset_pkg::ST_NORMAL;
          end
        end
        meter_reset_pkg::ST_NORMAL: begin
          // reset pin and software reset only act here
          if (!rstPinHigh) begin
            nxt_state = meter_reset_pkg::ST_RESET_HELD; // R16
          end else if (!modeIsNormal) begin
            nxt_state = meter_reset_pkg::ST_LOW_POWER;
          end else if (swRstReq) begin
            nxt_state = meter_reset_pkg::ST_SW_RESET; // R19
          end
        end
        meter_reset_pkg::ST_RESET_HELD: begin
          // a pulse shorter than the least width is dropped
          if (rstPinHigh) begin
            nxt_state = timerDone(cnt_ff, PULSE_LIM) ?
                        meter_reset_pkg::ST_RECOVER :
                        meter_reset_pkg::ST_NORMAL; // R17
          end
        end
        meter_reset_pkg::ST_RECOVER,
        meter_reset_pkg::ST_SW_RESET: begin
          if (timerDone(cnt_ff, XFER_LIM)) begin
            nxt_state = meter_reset_pkg::ST_NORMAL;
          end
        end
        meter_reset_pkg::ST_LOW_POWER: begin
          if (modeIsNormal) begin
            nxt_state = meter_reset_pkg::ST_RECOVER;
          end
        end
        default: begin
          nxt_state = meter_reset_pkg::ST_INACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff <= meter_reset_pkg::ST_INACTIVE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // timer restarts on every state change and saturates
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_ff <= CNT_ZERO;
    end else if (nxt_state != state_ff) begin
      cnt_ff <= CNT_ZERO;
    end else if (cnt_ff != CNT_MAX) begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  logic transEnd;
  logic transStart;
  logic enterNormal;
  logic hwResetEvt;
  logic swResetStart;

  assign enterNormal  = (nxt_state == meter_reset_pkg::ST_NORMAL) &&
                        (state_ff == meter_reset_pkg::ST_SETTLE ||
                         state_ff == meter_reset_pkg::ST_RECOVER);
  assign transEnd     = enterNormal ||
                        (state_ff == meter_reset_pkg::ST_SW_RESET &&
                         nxt_state == meter_reset_pkg::ST_NORMAL);
  assign transStart   = (nxt_state != state_ff) &&
                        (nxt_state == meter_reset_pkg::ST_SETTLE ||
                         nxt_state == meter_reset_pkg::ST_RECOVER ||
                         nxt_state == meter_reset_pkg::ST_SW_RESET);
  assign hwResetEvt   = (state_ff == meter_reset_pkg::ST_RESET_HELD) &&
                        (nxt_state == meter_reset_pkg::ST_RECOVER);
  assign swResetStart = (state_ff == meter_reset_pkg::ST_NORMAL) &&
                        (nxt_state == meter_reset_pkg::ST_SW_RESET);

  // reset-done flag and its interrupt pin; the set wins over a clear
  logic reset_done_flag_ff;
  logic doneIrqN_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reset_done_flag_ff  <= 1'b0;
      doneIrqN_ff <= 1'b1;
    end else if (transEnd) begin
      reset_done_flag_ff  <= 1'b1; // R10 R21
      doneIrqN_ff <= 1'b0;
    end else if (transStart || !supplyGood) begin
      reset_done_flag_ff  <= 1'b0; // R10
      doneIrqN_ff <= 1'b1;
    end else if (secondStatusWr &&
                 wrData[meter_reset_pkg::RESET_DONE_FLAG_BIT]) begin
      reset_done_flag_ff  <= 1'b0; // R11 R23
      doneIrqN_ff <= 1'b1;
    end
  end

  // default loads: full set on entering normal, core set on soft reset
  logic loadAll_ff;
  logic loadCore_ff;
  logic swRstBit_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      loadAll_ff  <= 1'b0;
      loadCore_ff <= 1'b0;
    end else begin
      loadAll_ff  <= enterNormal; // R9 R17
      loadCore_ff <= swResetStart; // R20
    end
  end

  // bit reads one through the whole soft reset, then clears itself
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      swRstBit_ff <= 1'b0;
    end else begin
      swRstBit_ff <= (nxt_state == meter_reset_pkg::ST_SW_RESET); // R21 R22
    end
  end

  // host port selection and lock
  logic                                  spi_ff;
  logic                                  i2cLock_ff;
  logic                                  spiLock_ff;
  logic [meter_reset_pkg::SS_CNT_W-1:0]  ssCnt_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst || hwResetEvt ||
        state_ff == meter_reset_pkg::ST_INACTIVE) begin
      spi_ff     <= 1'b0; // R7 R17
      i2cLock_ff <= 1'b0;
      spiLock_ff <= 1'b0;
      ssCnt_ff   <= meter_reset_pkg::SS_ZERO;
    end else if (swResetStart) begin
      // an unlocked choice falls back to I2C; a locked one stays
      if (!(i2cLock_ff || spiLock_ff)) begin
        spi_ff   <= 1'b0; // R20
        ssCnt_ff <= meter_reset_pkg::SS_ZERO;
      end
    end else if (state_ff == meter_reset_pkg::ST_NORMAL) begin // R8
      // outside normal mode nothing here moves, so locks persist
      if (secondCfgWr && spi_ff) begin
        spiLock_ff <= 1'b1; // R6
      end else if (secondCfgWr &&
                   wrData[meter_reset_pkg::I2C_LOCK_BIT]) begin
        i2cLock_ff <= 1'b1; // R5
      end
      if (ssFall && !spi_ff && !i2cLock_ff) begin
        if (ssCnt_ff == meter_reset_pkg::SS_LAST) begin
          spi_ff <= 1'b1; // R4
        end else begin
          ssCnt_ff <= ssCnt_ff + meter_reset_pkg::SS_ONE;
        end
      end
    end
  end

  // processor run control
  logic run_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst || state_ff != meter_reset_pkg::ST_NORMAL ||
        nxt_state != meter_reset_pkg::ST_NORMAL) begin
      run_ff <= 1'b0; // R13
    end else if (runWr) begin
      run_ff <= (wrData == meter_reset_pkg::RUN_START); // R13
    end
  end

  // summary status
  logic active_ff;
  logic normal_ff;
  logic busy_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      active_ff <= 1'b0;
      normal_ff <= 1'b0;
      busy_ff   <= 1'b0;
    end else begin
      active_ff <= !(nxt_state == meter_reset_pkg::ST_INACTIVE ||
                     nxt_state == meter_reset_pkg::ST_HOLD); // R1
      normal_ff <= (nxt_state == meter_reset_pkg::ST_NORMAL);
      busy_ff   <= !(nxt_state == meter_reset_pkg::ST_NORMAL ||
                     nxt_state == meter_reset_pkg::ST_LOW_POWER);
    end
  end

  assign deviceActive     = active_ff;
  assign normalMode       = normal_ff;
  assign transitionBusy   = busy_ff;
  assign resetDoneFlag    = reset_done_flag_ff;
  assign doneIrqN         = doneIrqN_ff;
  assign softwareResetBit = swRstBit_ff;
  assign spiActive        = spi_ff;
  assign i2cLocked        = i2cLock_ff;
  assign spiLocked        = spiLock_ff;
  assign dspRun           = run_ff;
  assign loadAllDefaults  = loadAll_ff;
  assign loadCoreDefaults = loadCore_ff;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence swResetDone;
    state_ff == meter_reset_pkg::ST_SW_RESET
    ##1 state_ff == meter_reset_pkg::ST_NORMAL;
  endsequence

  a_hold_time_met: assert property ( // R1
    (state_ff == meter_reset_pkg::ST_SETTLE &&
     $past(state_ff) == meter_reset_pkg::ST_HOLD) |->
    $past(cnt_ff) == HOLD_LIM)
    else $error("supply hold ended early");

  a_irq_tracks_flag: assert property ( // R10
    doneIrqN == !resetDoneFlag)
    else $error("interrupt pin disagrees with flag");

  a_flag_low_trans: assert property ( // R10
    (state_ff == meter_reset_pkg::ST_RECOVER ||
     state_ff == meter_reset_pkg::ST_SW_RESET ||
     state_ff == meter_reset_pkg::ST_SETTLE) |-> !reset_done_flag_ff)
    else $error("flag set during transition");

  a_sw_reset_end: assert property ( // R21
    swResetDone |-> reset_done_flag_ff && !swRstBit_ff && !doneIrqN_ff)
    else $error("soft reset end not signalled");

  a_flag_clear_write: assert property ( // R11
    (reset_done_flag_ff && secondStatusWr && wrData[meter_reset_pkg::RESET_DONE_FLAG_BIT]
     && !transEnd) |=> !reset_done_flag_ff && doneIrqN_ff)
    else $error("flag not cleared by write");

  a_zero_write_keeps: assert property ( // R23
    (state_ff == meter_reset_pkg::ST_NORMAL && secondStatusWr &&
     !wrData[meter_reset_pkg::RESET_DONE_FLAG_BIT] &&
     nxt_state == meter_reset_pkg::ST_NORMAL) |=> $stable(reset_done_flag_ff))
    else $error("zero write changed flag");

  a_sw_reset_ignored: assert property ( // R22
    (state_ff == meter_reset_pkg::ST_LOW_POWER && swRstReq) |=>
    state_ff != meter_reset_pkg::ST_SW_RESET && !swRstBit_ff)
    else $error("soft reset taken outside normal mode");

  a_pin_reset_normal: assert property ( // R16
    (state_ff != meter_reset_pkg::ST_NORMAL &&
     state_ff != meter_reset_pkg::ST_RESET_HELD) |=>
    state_ff != meter_reset_pkg::ST_RESET_HELD)
    else $error("pin reset taken outside normal mode");

  a_i2c_lock_holds: assert property ( // R5
    i2cLocked |=> !$rose(spiActive))
    else $error("port moved to SPI under I2C lock");

  a_spi_third_fall: assert property ( // R4
    $rose(spiActive) |-> $past(ssCnt_ff) == meter_reset_pkg::SS_LAST)
    else $error("SPI chosen before third fall");

  a_dsp_idle_trans: assert property ( // R13
    (state_ff != meter_reset_pkg::ST_NORMAL) |=> !dspRun)
    else $error("processor running outside normal mode");

  a_short_pulse_nop: assert property ( // R17
    (state_ff == meter_reset_pkg::ST_NORMAL &&
     $past(state_ff) == meter_reset_pkg::ST_RESET_HELD) |->
    !loadAllDefaults && $stable(spiLocked))
    else $error("short reset pulse had an effect");

endmodule

`default_nettype wire

// *** design/meter_reset_pkg.sv ***
/*
  Constants, encodings and state types for the metering reset, power-up
  and host port select sequencer.
  Assumes a single 40 MHz core clock; all times are converted to cycles
  of that clock here.
*/
`default_nettype none

package meter_reset_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_US     = 1000;
  localparam int NS_PER_MS     = 1000000;

  // supply monitor hold after threshold crossing
  localparam int SUPPLY_HOLD_MS  = 26;
  localparam int HOLD_CYCLES_DEF = SUPPLY_HOLD_MS * NS_PER_MS / CLK_PERIOD_NS;

  // full functionality after power is complete
  localparam int FULL_FUNC_MS      = 40;
  localparam int SETTLE_CYCLES_DEF =
    (FULL_FUNC_MS - SUPPLY_HOLD_MS) * NS_PER_MS / CLK_PERIOD_NS;

  // least reset pulse width, rounded up
  localparam int RESET_PULSE_MIN_US = 10;
  localparam int RESET_PULSE_CYCLES =
    (RESET_PULSE_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // length of a reset or wake transition
  localparam int XFER_TIME_US = 20;
  localparam int XFER_CYCLES  = XFER_TIME_US * NS_PER_US / CLK_PERIOD_NS;

  // timer width covers the longest default count
  localparam int CNT_W = 21;

  // host port select
  localparam int          SS_CNT_W = 2;
  localparam logic [1:0]  SS_LAST  = 2'h2;
  localparam logic [1:0]  SS_ZERO  = 2'h0;
  localparam logic [1:0]  SS_ONE   = 2'h1;

  // register fields
  localparam int          DATA_W       = 16;
  localparam int          SOFTWARE_RESET_BIT_BIT    = 7;
  localparam int          I2C_LOCK_BIT = 1;
  localparam int          RESET_DONE_FLAG_BIT  = 15;
  localparam logic [15:0] RUN_START    = 16'h0001;

  // power mode pin codes {pin b, pin a}
  localparam logic [1:0] PINS_NORMAL  = 2'h1;
  localparam logic [1:0] PINS_REDUCED = 2'h0;
  localparam logic [1:0] PINS_LOW     = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL  = 2'h0,
    MODE_REDUCED = 2'h1,
    MODE_LOW     = 2'h2,
    MODE_SLEEP   = 2'h3
  } mode_type;

  // gray coded in declaration order and along the power-up path
  typedef enum logic [2:0] {
    ST_INACTIVE   = 3'h0,
    ST_HOLD       = 3'h1,
    ST_SETTLE     = 3'h3,
    ST_NORMAL     = 3'h2,
    ST_RESET_HELD = 3'h6,
    ST_RECOVER    = 3'h7,
    ST_SW_RESET   = 3'h5,
    ST_LOW_POWER  = 3'h4
  } state_type;

endpackage

`default_nettype wire

// *** sim/meter_host_model.sv ***
/*
  Host microcontroller model: drives the power mode, reset and slave
  select pins and issues one-cycle register write strobes.
  Assumes its tasks are called from one process, on the bench clock.
*/
`default_nettype none

module meter_host_model (
  // clock and interrupt
  input  wire logic        ref_clk,
  input  wire logic        doneIrqN,
  // pins
  output logic             powerModePinA,
  output logic             powerModePinB,
  output logic             resetPinN,
  output logic             slaveSelectPinN,
  // register writes
  output logic             cfgWr,
  output logic             secondCfgWr,
  output logic             secondStatusWr,
  output logic             runWr,
  output logic [15:0]      wrData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    powerModePinB = 1'b0;
    powerModePinA = 1'b1;
    // power-up timing is kept, so no modulator fix writes are owed
    resetPinN = 1'b1;
    slaveSelectPinN = 1'b1;
    put(4, 16'h0000);
  end

  // which: 0 config, 1 second config, 2 second status, 3 run, else idle
  task automatic put(input int which, input logic [15:0] d);
    wrData = d;
    cfgWr = (which == 0);
    secondCfgWr = (which == 1);
    secondStatusWr = (which == 2);
    runWr = (which == 3);
  endtask

  task automatic wr(input int which, input logic [15:0] d);
    @(negedge ref_clk);
    put(which, d);
    @(negedge ref_clk);
    // idle data is scrambled so nothing can lean on a stale word
    put(4, ~d);
  endtask

  task automatic setMode(input logic [1:0] pins);
    @(negedge ref_clk);
    {powerModePinB, powerModePinA} = pins;
  endtask

  task automatic resetPulse(input int cycles);
    @(negedge ref_clk);
    resetPinN = 1'b0;
    repeat (cycles) @(negedge ref_clk);
    resetPinN = 1'b1;
  endtask

  // a wide gap models a slow host; each level must outlast the synchroniser
  task automatic toggleSs(input int n, input int gap);
    repeat (n) begin
      @(negedge ref_clk);
      slaveSelectPinN = 1'b0;
      repeat (gap) @(negedge ref_clk);
      slaveSelectPinN = 1'b1;
      repeat (gap) @(negedge ref_clk);
    end
  endtask

  task automatic ackDone(output logic seen);
    int k;
    seen = 1'b0;
    for (k = 0; k < 2000 && !seen; k++) begin
      @(negedge ref_clk);
      seen = (doneIrqN === 1'b0);
    end
    if (seen) wr(2, 16'hFFFF);
  endtask
endmodule

`default_nettype wire

// *** sim/meter_reset_port_select_seq_tb.sv ***
/*
  Self-checking bench for the reset and port select sequencer.
  Assumes the host model drives all pins and writes; supply is driven here.
*/
`default_nettype none

module meter_reset_port_select_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD   = 20;
  localparam int SETTLE = 10;

  logic        ref_clk, nrst, supplyOk;
  logic        powerModePinA, powerModePinB, resetPinN, slaveSelectPinN;
  logic        cfgWr, secondCfgWr, secondStatusWr, runWr;
  logic [15:0] wrData;
  logic        deviceActive, normalMode, transitionBusy, resetDoneFlag;
  logic        doneIrqN, softwareResetBit, spiActive, i2cLocked, spiLocked;
  logic        dspRun, loadAllDefaults, loadCoreDefaults;
  int          failCount, numChecks;
  logic [31:0] rnd;
  logic [7:0]  notes[$];
  logic [7:0]  noteExp;
  logic        prevFlag, seen;

  meter_reset_port_select_seq #(.HOLD_CYCLES(HOLD), .SETTLE_CYCLES(SETTLE))
    u_meter_reset_port_select_seq (
    .ref_clk(ref_clk), .nrst(nrst), .supplyOk(supplyOk),
    .powerModePinA(powerModePinA), .powerModePinB(powerModePinB),
    .resetPinN(resetPinN), .slaveSelectPinN(slaveSelectPinN),
    .cfgWr(cfgWr), .secondCfgWr(secondCfgWr),
    .secondStatusWr(secondStatusWr), .runWr(runWr), .wrData(wrData),
    .deviceActive(deviceActive), .normalMode(normalMode),
    .transitionBusy(transitionBusy), .resetDoneFlag(resetDoneFlag),
    .doneIrqN(doneIrqN), .softwareResetBit(softwareResetBit),
    .spiActive(spiActive), .i2cLocked(i2cLocked), .spiLocked(spiLocked),
    .dspRun(dspRun), .loadAllDefaults(loadAllDefaults),
    .loadCoreDefaults(loadCoreDefaults));

  meter_host_model u_meter_host_model (
    .ref_clk(ref_clk), .doneIrqN(doneIrqN),
    .powerModePinA(powerModePinA), .powerModePinB(powerModePinB),
    .resetPinN(resetPinN), .slaveSelectPinN(slaveSelectPinN),
    .cfgWr(cfgWr), .secondCfgWr(secondCfgWr),
    .secondStatusWr(secondStatusWr), .runWr(runWr), .wrData(wrData));

  always #12.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // {irq, all defaults, core defaults, spi, spi lock, i2c lock, software_reset_bit, run}
  function automatic logic [7:0] snap();
    return {doneIrqN, loadAllDefaults, loadCoreDefaults, spiActive,
            spiLocked, i2cLocked, softwareResetBit, dspRun};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic testDone();
    $display("checks=%0d errors=%0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic waitFlag(input int lim);
    int k;
    for (k = 0; k < lim && resetDoneFlag !== 1'b1; k++) @(negedge ref_clk);
    check({15'h0000, resetDoneFlag}, 16'h0001);
  endtask

  task automatic ack();
    u_meter_host_model.ackDone(seen);
    check({14'h0000, resetDoneFlag, doneIrqN}, 16'h0001);
  endtask

  // end of every transition is compared against the oldest note
  always @(negedge ref_clk) begin
    if (nrst === 1'b1 && resetDoneFlag === 1'b1 && prevFlag !== 1'b1) begin
      if (notes.size() == 0)
        check({8'h00, snap()}, 16'hFFFF);
      else begin
        noteExp = notes.pop_front();
        check({8'h00, snap()}, {8'h00, noteExp});
      end
    end
    prevFlag = resetDoneFlag;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failCount++;
    testDone();
  end

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    supplyOk = 1'b0;
    rnd = 32'h7B7C4A19;
    failCount = 0;
    numChecks = 0;
    prevFlag = 1'b0;
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
    supplyOk = 1'b1;
    notes.push_back(8'h40);
    repeat (HOLD / 2) @(negedge ref_clk);
    check({15'h0000, deviceActive}, 16'h0000);
    waitFlag(HOLD + SETTLE + 20);
    u_meter_host_model.wr(2, 16'h7FFF);
    check({14'h0000, resetDoneFlag, doneIrqN}, 16'h0002);
    ack();
    u_meter_host_model.wr(3, 16'h0001);
    check({15'h0000, dspRun}, 16'h0001);
    rnd = lfsrNext(rnd);
    u_meter_host_model.wr(3, rnd[15:0] | 16'h0002);
    check({15'h0000, dspRun}, 16'h0000);
    u_meter_host_model.wr(3, 16'h0001);
    u_meter_host_model.toggleSs(2, 4);
    repeat (4) @(negedge ref_clk);
    check({15'h0000, spiActive}, 16'h0000);
    u_meter_host_model.toggleSs(1, 4);
    repeat (4) @(negedge ref_clk);
    check({15'h0000, spiActive}, 16'h0001);
    rnd = lfsrNext(rnd);
    u_meter_host_model.wr(1, rnd[15:0] & 16'hFFFD);
    check({14'h0000, spiLocked, i2cLocked}, 16'h0002);
    notes.push_back(8'h18);
    rnd = lfsrNext(rnd);
    u_meter_host_model.wr(0, rnd[15:0] | 16'h0080);
    check({12'h000, transitionBusy, softwareResetBit, resetDoneFlag,
           dspRun}, 16'h000C);
    waitFlag(1000);
    ack();
    u_meter_host_model.setMode(2'h2);
    repeat (6) @(negedge ref_clk);
    check({14'h0000, normalMode, transitionBusy}, 16'h0000);
    u_meter_host_model.wr(0, 16'h0080);
    check({15'h0000, softwareResetBit}, 16'h0000);
    u_meter_host_model.resetPulse(450);
    repeat (6) @(negedge ref_clk);
    check({14'h0000, spiActive, spiLocked}, 16'h0003);
    notes.push_back(8'h58);
    u_meter_host_model.setMode(2'h1);
    waitFlag(1000);
    ack();
    u_meter_host_model.resetPulse(100);
    repeat (10) @(negedge ref_clk);
    check({14'h0000, normalMode, spiLocked}, 16'h0003);
    notes.push_back(8'h40);
    u_meter_host_model.resetPulse(450);
    waitFlag(1000);
    ack();
    u_meter_host_model.toggleSs(3, 4);
    repeat (4) @(negedge ref_clk);
    check({15'h0000, spiActive}, 16'h0001);
    notes.push_back(8'h40);
    u_meter_host_model.resetPulse(450);
    waitFlag(1000);
    ack();
    u_meter_host_model.wr(1, 16'h0002);
    check({15'h0000, i2cLocked}, 16'h0001);
    u_meter_host_model.toggleSs(3, 4);
    repeat (4) @(negedge ref_clk);
    check({15'h0000, spiActive}, 16'h0000);
    supplyOk = 1'b0;
    repeat (6) @(negedge ref_clk);
    check({12'h000, deviceActive, normalMode, i2cLocked, dspRun},
          16'h0000);
    check(16'(notes.size()), 16'h0000);
    testDone();
  end
endmodule

`default_nettype wire
